// *** common/docc_pkg.sv ***
// Constants shared by the digital output channel conditioning design.
// Assumes a 250 MHz system clock and a plain word-wide register port.
package docc_pkg;

	// ****************************************
	// Sizes and timing
	// ****************************************
	localparam int NCH = 8;
	localparam int DW = 32;
	localparam int AW = 8;
	localparam int DLYW = 16;
	localparam int CLK_NS = 4;
	localparam int MS_NS = 1000000;
	localparam int MS_CYC = MS_NS / CLK_NS;
	localparam int WD_MS = 500;
	localparam logic [1:0] WD_FAIL_LAST = 2'h2;
	localparam logic [9:0] WD_MS_LAST = 10'(WD_MS - 1);

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
	localparam logic [AW-1:0] ADDR_SIM_EN = 8'h04;
	localparam logic [AW-1:0] ADDR_SIM_VAL = 8'h08;
	localparam logic [AW-1:0] ADDR_SIM_INV = 8'h0C;
	localparam logic [AW-1:0] ADDR_EMODE = 8'h10;
	localparam logic [AW-1:0] ADDR_SUBST = 8'h14;
	localparam logic [AW-1:0] ADDR_NEG = 8'h18;
	localparam logic [AW-1:0] ADDR_STATUS = 8'h20;
	localparam logic [AW-1:0] ADDR_LFLT = 8'h24;
	localparam logic [AW-1:0] ADDR_IRQ_STAT = 8'h28;
	localparam logic [AW-1:0] ADDR_IRQ_CLR = 8'h2C;
	localparam logic [AW-1:0] ADDR_IRQ_EN = 8'h30;
	localparam logic [2:0] PAGE_ON_DLY = 3'h2;
	localparam logic [2:0] PAGE_OFF_DLY = 3'h3;

	// ****************************************
	// Fields and values
	// ****************************************
	localparam int CTRL_ACT_BIT = 0;
	localparam int STAT_INV_LSB = 8;
	localparam int STAT_OFF_BIT = 16;
	localparam int STAT_ARM_BIT = 17;
	localparam int IRQ_WD_BIT = 0;
	localparam int IRQ_INV_BIT = 1;
	localparam int NIRQ = 2;
	localparam logic [1:0] EM_CUR = 2'h0;
	localparam logic [1:0] EM_SUB = 2'h1;
	localparam logic [1:0] EM_LAST = 2'h2;
	localparam logic [DW-1:0] ZERO_W = 32'h0000_0000;

	typedef enum logic [1:0] {WD_IDLE, WD_ARMED, WD_OFF} docc_wd_type;

endpackage

// *** core/docc_dly.sv ***
// One channel's ON-delay and OFF-delay filter.
// Assumes a one-cycle millisecond tick from the parent.
`timescale 1ns/1ps
`default_nettype none
module docc_dly
	import docc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ms_tick,
	input wire logic din,
	input wire logic [DLYW-1:0] on_ms,
	input wire logic [DLYW-1:0] off_ms,
	output logic q
);

	logic [DLYW-1:0] cnt_r;
	logic [DLYW-1:0] cnt_nxt;
	logic q_nxt;
	wire logic differ = din != q;
	wire logic [DLYW-1:0] lim = din ? on_ms : off_ms;
	wire logic done = differ && (cnt_r >= lim);

	// ****************************************
	// Filter
	// ****************************************
	assign q_nxt = done ? din : q;
	assign cnt_nxt = (!differ || done) ? '0 : (ms_tick ? cnt_r + 16'h0001 : cnt_r);

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			q <= 1'b0;
			cnt_r <= '0;
		end
		else
		begin
			q <= q_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_on_hold: assert property (@(posedge clk_sys) disable iff (rst)
		(!q && din && cnt_r < on_ms) |=> !q)
		else $error("Output rose before the ON-delay elapsed.");
	a_off_hold: assert property (@(posedge clk_sys) disable iff (rst)
		(q && !din && cnt_r < off_ms) |=> q)
		else $error("Output fell before the OFF-delay elapsed.");

endmodule
`default_nettype wire

// *** core/docc_top.sv ***
// Digital output channel conditioning: source select, error strategy, negation, delays, watchdog.
// Assumes inputs synchronous to clk_sys and a register master that never waits.
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - After three failed attempts in a row to talk to the communication unit, outputs go off 500 ms later.
// - There is no line fault detection, so no line fault is ever reported or acted on.
// - In normal mode each channel takes the latest bus value and drives it out.
// - In simulation mode each channel takes its programmed simulated value instead of the bus value.
// - The error strategy runs when the watchdog has expired or when the value carries invalid status.
// - A line fault never starts the substitute strategy.
// - In current value strategy the incoming value, possibly simulated, passes unchanged despite the error.
// - In substitute strategy the channel drives its programmed substitute bit while the error lasts.
// - In last valid strategy the channel holds the last value captured before the fault.
// - With negation on, the channel inverts its output value.
// - Each rise of the output is delayed by the ON-delay in milliseconds, filtering short high pulses.
// - Every channel is active only while the module active setting is on.
// - Each fall of the output is delayed by the OFF-delay in milliseconds, filtering short low gaps.
// - A substitute value is always reported together with invalid status.
module docc_top
	import docc_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYC
)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [AW-1:0] reg_addr,
	input wire logic [DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DW-1:0] reg_rdata,
	input wire logic bus_we,
	input wire logic [NCH-1:0] bus_val,
	input wire logic [NCH-1:0] bus_inv,
	input wire logic com_att,
	input wire logic com_fail,
	output logic [NCH-1:0] dout,
	output logic [NCH-1:0] dout_inv,
	output logic irq
);

	// ****************************************
	// Configuration registers
	// ****************************************
	logic act_r;
	logic [NCH-1:0] sim_r;
	logic [NCH-1:0] sim_val_r;
	logic [NCH-1:0] sim_inv_r;
	logic [2*NCH-1:0] emode_r;
	logic [NCH-1:0] subst_r;
	logic [NCH-1:0] neg_r;
	logic [NIRQ-1:0] irq_en_r;
	logic [NIRQ-1:0] irq_st_r;
	logic [NIRQ-1:0] irq_st_nxt;
	logic [DW-1:0] rdata_nxt;
	logic [DLYW*NCH-1:0] on_flat;
	logic [DLYW*NCH-1:0] off_flat;

	wire logic w_ctrl = reg_wr && reg_addr == ADDR_CTRL;
	wire logic w_sim = reg_wr && reg_addr == ADDR_SIM_EN;
	wire logic w_simv = reg_wr && reg_addr == ADDR_SIM_VAL;
	wire logic w_simi = reg_wr && reg_addr == ADDR_SIM_INV;
	wire logic w_emode = reg_wr && reg_addr == ADDR_EMODE;
	wire logic w_subst = reg_wr && reg_addr == ADDR_SUBST;
	wire logic w_neg = reg_wr && reg_addr == ADDR_NEG;
	wire logic w_iclr = reg_wr && reg_addr == ADDR_IRQ_CLR;
	wire logic w_ien = reg_wr && reg_addr == ADDR_IRQ_EN;
	wire logic [2:0] page = reg_addr[AW-1:5];
	wire logic [2:0] dix = reg_addr[4:2];
	wire logic w_on = reg_wr && page == PAGE_ON_DLY && reg_addr[1:0] == 2'h0;
	wire logic w_off = reg_wr && page == PAGE_OFF_DLY && reg_addr[1:0] == 2'h0;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			act_r <= 1'b0;
			sim_r <= '0;
			sim_val_r <= '0;
			sim_inv_r <= '0;
			emode_r <= '0;
			subst_r <= '0;
			neg_r <= '0;
			irq_en_r <= '0;
		end
		else
		begin
			if (w_ctrl)
				act_r <= reg_wdata[CTRL_ACT_BIT];
			if (w_sim)
				sim_r <= reg_wdata[NCH-1:0];
			if (w_simv)
				sim_val_r <= reg_wdata[NCH-1:0];
			if (w_simi)
				sim_inv_r <= reg_wdata[NCH-1:0];
			if (w_emode)
				emode_r <= reg_wdata[2*NCH-1:0];
			if (w_subst)
				subst_r <= reg_wdata[NCH-1:0];
			if (w_neg)
				neg_r <= reg_wdata[NCH-1:0];
			if (w_ien)
				irq_en_r <= reg_wdata[NIRQ-1:0];
		end
	end

	// ****************************************
	// Millisecond tick
	// ****************************************
	logic [31:0] ms_cnt_r;
	logic ms_tick_r;
	wire logic ms_wrap = ms_cnt_r == 32'(MS_CYCLES - 1);

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			ms_cnt_r <= '0;
			ms_tick_r <= 1'b0;
		end
		else
		begin
			ms_cnt_r <= ms_wrap ? '0 : ms_cnt_r + 32'h0000_0001;
			ms_tick_r <= ms_wrap;
		end
	end

	// ****************************************
	// Communication watchdog
	// ****************************************
	docc_wd_type st_r;
	docc_wd_type st_nxt;
	logic [1:0] fail_cnt_r;
	logic [1:0] fail_cnt_nxt;
	logic [9:0] wd_ms_r;
	logic [9:0] wd_ms_nxt;

	wire logic att_ok = com_att && !com_fail;
	wire logic att_bad = com_att && com_fail;
	wire logic wd_off = st_r == WD_OFF;

	always_comb
	begin
		st_nxt = st_r;
		fail_cnt_nxt = fail_cnt_r;
		wd_ms_nxt = wd_ms_r;
		case (st_r)
			WD_IDLE:
			begin
				if (att_bad && fail_cnt_r == WD_FAIL_LAST)
				begin
					st_nxt = WD_ARMED;
					wd_ms_nxt = '0;
				end
				else if (att_bad)
					fail_cnt_nxt = fail_cnt_r + 2'h1;
			end
			WD_ARMED:
			begin
				if (ms_tick_r && wd_ms_r == WD_MS_LAST)
					st_nxt = WD_OFF;
				else if (ms_tick_r)
					wd_ms_nxt = wd_ms_r + 10'h001;
			end
			WD_OFF:
				st_nxt = WD_OFF;
			default:
				st_nxt = WD_IDLE;
		endcase
		if (att_ok)
		begin
			st_nxt = WD_IDLE;
			fail_cnt_nxt = '0;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			st_r <= WD_IDLE;
			fail_cnt_r <= '0;
			wd_ms_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
			fail_cnt_r <= fail_cnt_nxt;
			wd_ms_r <= wd_ms_nxt;
		end
	end

	// ****************************************
	// Channel conditioning
	// ****************************************
	logic [NCH-1:0] bus_val_r;
	logic [NCH-1:0] bus_inv_r;
	logic [NCH-1:0] lastv_r;
	logic [NCH-1:0] cond_r;
	logic [NCH-1:0] cond_nxt;
	logic [NCH-1:0] rep_inv_nxt;
	logic [NCH-1:0] is_cur;
	logic [NCH-1:0] is_sub;
	logic [NCH-1:0] is_last;
	logic [NCH-1:0] filt;

	wire logic [NCH-1:0] src_w = (sim_r & sim_val_r) | (~sim_r & bus_val_r);
	wire logic [NCH-1:0] srcinv_w = (sim_r & sim_inv_r) | (~sim_r & bus_inv_r);
	wire logic [NCH-1:0] err_w = srcinv_w | {NCH{wd_off}};

	genvar i;
	generate
		for (i = 0; i < NCH; i++)
		begin : g_ch
			logic [DLYW-1:0] on_r;
			logic [DLYW-1:0] off_r;
			wire logic [1:0] mode = emode_r[2*i+1:2*i];
			wire logic sel = (err_w[i] && mode == EM_SUB) ? subst_r[i] :
				(err_w[i] && mode == EM_LAST) ? lastv_r[i] : src_w[i];

			assign is_cur[i] = mode == EM_CUR;
			assign is_sub[i] = mode == EM_SUB;
			assign is_last[i] = mode == EM_LAST;
			assign cond_nxt[i] = sel ^ neg_r[i];
			assign rep_inv_nxt[i] = (err_w[i] && mode != EM_CUR) || srcinv_w[i];
			assign on_flat[DLYW*i +: DLYW] = on_r;
			assign off_flat[DLYW*i +: DLYW] = off_r;

			always_ff @(posedge clk_sys)
			begin
				if (rst)
				begin
					on_r <= '0;
					off_r <= '0;
				end
				else
				begin
					if (w_on && dix == 3'(i))
						on_r <= reg_wdata[DLYW-1:0];
					if (w_off && dix == 3'(i))
						off_r <= reg_wdata[DLYW-1:0];
				end
			end

			docc_dly u_dly (
				.clk_sys(clk_sys),
				.rst(rst),
				.ms_tick(ms_tick_r),
				.din(cond_r[i]),
				.on_ms(on_r),
				.off_ms(off_r),
				.q(filt[i])
			);
		end
	endgenerate

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			bus_val_r <= '0;
			bus_inv_r <= '0;
			lastv_r <= '0;
			cond_r <= '0;
			dout <= '0;
			dout_inv <= '0;
		end
		else
		begin
			if (bus_we)
			begin
				bus_val_r <= bus_val;
				bus_inv_r <= bus_inv;
			end
			lastv_r <= (lastv_r & err_w) | (src_w & ~err_w);
			cond_r <= cond_nxt;
			dout <= filt & {NCH{act_r && !wd_off}};
			dout_inv <= rep_inv_nxt;
		end
	end

	// ****************************************
	// Interrupts and register read
	// ****************************************
	wire logic [NIRQ-1:0] ev = {bus_we && (|bus_inv), st_r == WD_ARMED && st_nxt == WD_OFF};
	wire logic [NIRQ-1:0] clr = w_iclr ? reg_wdata[NIRQ-1:0] : '0;

	assign irq_st_nxt = (irq_st_r & ~clr) | ev;
	assign rdata_nxt = !reg_rd ? ZERO_W :
		reg_addr == ADDR_CTRL ? DW'(act_r) :
		reg_addr == ADDR_SIM_EN ? DW'(sim_r) :
		reg_addr == ADDR_SIM_VAL ? DW'(sim_val_r) :
		reg_addr == ADDR_SIM_INV ? DW'(sim_inv_r) :
		reg_addr == ADDR_EMODE ? DW'(emode_r) :
		reg_addr == ADDR_SUBST ? DW'(subst_r) :
		reg_addr == ADDR_NEG ? DW'(neg_r) :
		reg_addr == ADDR_STATUS ? DW'({st_r == WD_ARMED, wd_off, dout_inv, dout}) :
		reg_addr == ADDR_IRQ_STAT ? DW'(irq_st_r) :
		reg_addr == ADDR_IRQ_EN ? DW'(irq_en_r) :
		(page == PAGE_ON_DLY && reg_addr[1:0] == 2'h0) ? DW'(on_flat[DLYW*dix +: DLYW]) :
		(page == PAGE_OFF_DLY && reg_addr[1:0] == 2'h0) ? DW'(off_flat[DLYW*dix +: DLYW]) :
		ZERO_W;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			irq_st_r <= '0;
			irq <= 1'b0;
			reg_rdata <= ZERO_W;
		end
		else
		begin
			irq_st_r <= irq_st_nxt;
			irq <= |(irq_st_r & irq_en_r);
			reg_rdata <= rdata_nxt;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	a_reset_off: assert property (disable iff (1'b0) rst |=> dout == '0)
		else $error("Outputs not off after reset.");
	a_wd_arm: assert property ((st_r == WD_IDLE && att_bad && fail_cnt_r == WD_FAIL_LAST) |=> st_r == WD_ARMED)
		else $error("Third failed attempt did not arm the watchdog.");
	a_wd_clear: assert property (att_ok |=> (st_r == WD_IDLE && fail_cnt_r == '0))
		else $error("Good attempt did not clear the watchdog.");
	a_wd_off: assert property (wd_off |=> dout == '0)
		else $error("Outputs not off after watchdog expiry.");
	a_inactive_off: assert property (!act_r |=> dout == '0)
		else $error("Output driven while module inactive.");
	a_line_zero: assert property ((reg_rd && reg_addr == ADDR_LFLT) |=> reg_rdata == ZERO_W)
		else $error("Line fault status read as nonzero.");
	a_cur_pass: assert property (((cond_r ^ $past(bus_val_r ^ neg_r)) & $past(~sim_r & (is_cur | ~err_w))) == '0)
		else $error("Bus value not passed to the channel.");
	a_sim_pass: assert property (((cond_r ^ $past(sim_val_r ^ neg_r)) & $past(sim_r & (is_cur | ~err_w))) == '0)
		else $error("Simulated value not passed to the channel.");
	a_subst_val: assert property (((cond_r ^ $past(subst_r ^ neg_r)) & $past(err_w & is_sub)) == '0)
		else $error("Substitute bit not applied during error.");
	a_subst_inv: assert property (((dout_inv ^ $past(err_w & is_sub)) & $past(err_w & is_sub)) == '0)
		else $error("Substitute value reported without invalid status.");
	a_last_hold: assert property (((lastv_r ^ $past(lastv_r)) & $past(err_w & is_last)) == '0)
		else $error("Last valid value changed during error.");

	c_wd_trip: cover property (st_r == WD_ARMED ##1 st_r == WD_OFF);
	c_subst_used: cover property (|(err_w & is_sub & ~sim_r));
	c_last_used: cover property (|(err_w & is_last) ##1 |(err_w & is_last));
	c_sim_out: cover property (|(sim_r & dout));

endmodule
`default_nettype wire

// *** dv/docc_comm_model.sv ***
// Behavioural model of the communication unit on the backplane.
// Assumes the testbench drives its command inputs right after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module docc_comm_model
	import docc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic send,
	input wire logic [NCH-1:0] val,
	input wire logic [NCH-1:0] inv,
	input wire logic att,
	input wire logic fail,
	output logic bus_we,
	output logic [NCH-1:0] bus_val,
	output logic [NCH-1:0] bus_inv,
	output logic com_att,
	output logic com_fail
);
	// ****************************************
	// Process data and attempt pulses
	// ****************************************
	logic [NCH-1:0] last_r;
	always_ff @(posedge clk_sys)
	begin
		bus_we <= send & ~rst;
		com_att <= att & ~rst;
		com_fail <= att ? fail : ~com_fail;
		if (send)
		begin
			bus_val <= val;
			bus_inv <= inv;
			last_r <= val;
		end
		else
		begin
			// Data lines are not held between frames.
			bus_val <= ~last_r;
			bus_inv <= ~bus_inv;
		end
	end
endmodule
`default_nettype wire

// *** dv/digital_output_channel_conditioning_tb.sv ***
// Self-checking testbench for the channel conditioning block.
// Assumes a shortened millisecond of 10 clock cycles.
`timescale 1ns/1ps
`default_nettype none
module digital_output_channel_conditioning_tb;
	import docc_pkg::*;
	localparam int MSC = 10;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [AW-1:0] reg_addr = 8'h00;
	logic [DW-1:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [DW-1:0] reg_rdata;
	logic bus_we, com_att, com_fail, irq;
	logic [NCH-1:0] bus_val, bus_inv, dout, dout_inv;
	logic m_send = 1'b0;
	logic m_att = 1'b0;
	logic m_fail = 1'b0;
	logic [NCH-1:0] m_val = 8'h00;
	logic [NCH-1:0] m_inv = 8'h00;
	logic [DW-1:0] rv;
	logic seen;
	int n_errors = 0;
	int total_checks = 0;
	int cyc = 0;

	always #2 clk_sys = ~clk_sys;

	docc_top #(.MS_CYCLES(MSC)) docc_top_inst (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_we(bus_we),
		.bus_val(bus_val), .bus_inv(bus_inv), .com_att(com_att), .com_fail(com_fail), .dout(dout),
		.dout_inv(dout_inv), .irq(irq));

	docc_comm_model docc_comm_model_inst (.clk_sys(clk_sys), .rst(rst), .send(m_send), .val(m_val),
		.inv(m_inv), .att(m_att), .fail(m_fail), .bus_we(bus_we), .bus_val(bus_val), .bus_inv(bus_inv),
		.com_att(com_att), .com_fail(com_fail));

	// ****************************************
	// Access tasks
	// ****************************************
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic chk(input string nm, input logic [DW-1:0] e, input logic [DW-1:0] g);
		total_checks++;
		if (g !== e)
		begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask

	task automatic rdchk(input logic [AW-1:0] a, input logic [DW-1:0] e, input string nm);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		rv = reg_rdata;
		chk(nm, e, rv);
	endtask

	task automatic send(input logic [NCH-1:0] v, input logic [NCH-1:0] i);
		@(posedge clk_sys);
		m_send <= 1'b1;
		m_val <= v;
		m_inv <= i;
		@(posedge clk_sys);
		m_send <= 1'b0;
	endtask

	task automatic att(input logic f);
		@(posedge clk_sys);
		m_att <= 1'b1;
		m_fail <= f;
		@(posedge clk_sys);
		m_att <= 1'b0;
	endtask

	task automatic waitc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic mon(input int n);
		repeat (n)
		begin
			@(posedge clk_sys);
			#1;
			seen = seen | dout[0];
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc > 20000)
		begin
			n_errors++;
			print_verdict();
		end
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial
	begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		waitc(1);
		chk("dout", 8'h00, dout);
		rdchk(ADDR_LFLT, 32'h0000_0000, "line fault");
		send(8'hFF, 8'h00);
		waitc(8);
		chk("dout", 8'h00, dout);
		wr(ADDR_CTRL, 32'h0000_0001);
		send(8'hA5, 8'h00);
		waitc(8);
		chk("dout", 8'hA5, dout);
		rdchk(ADDR_STATUS, 32'h0000_00A5, "status");
		wr(ADDR_NEG, 32'h0000_000F);
		waitc(8);
		chk("dout", 8'hAA, dout);
		wr(ADDR_NEG, 32'h0000_0000);
		$display("test normal done");
		wr(ADDR_SIM_EN, 32'h0000_00FF);
		wr(ADDR_SIM_VAL, 32'h0000_003C);
		waitc(8);
		chk("dout", 8'h3C, dout);
		wr(ADDR_EMODE, 32'h0000_0001);
		wr(ADDR_SUBST, 32'h0000_0001);
		wr(ADDR_SIM_INV, 32'h0000_0001);
		waitc(8);
		chk("dout", 8'h3D, dout);
		chk("dout_inv", 8'h01, dout_inv);
		wr(ADDR_SIM_EN, 32'h0000_0000);
		wr(ADDR_SIM_INV, 32'h0000_0000);
		wr(ADDR_SUBST, 32'h0000_0000);
		$display("test simulation done");
		wr(ADDR_EMODE, 32'h0000_00E4);
		wr(ADDR_IRQ_EN, 32'h0000_0002);
		send(8'h05, 8'h00);
		waitc(8);
		chk("dout", 8'h05, dout);
		send(8'h0A, 8'hFF);
		waitc(8);
		chk("dout", 8'h0C, dout);
		chk("dout_inv", 8'hFF, dout_inv);
		chk("irq", 1'b1, irq);
		rdchk(ADDR_IRQ_STAT, 32'h0000_0002, "irq status");
		wr(ADDR_IRQ_EN, 32'h0000_0000);
		waitc(2);
		chk("irq", 1'b0, irq);
		wr(ADDR_IRQ_CLR, 32'h0000_0002);
		rdchk(ADDR_IRQ_STAT, 32'h0000_0000, "irq status");
		wr(ADDR_IRQ_EN, 32'h0000_0002);
		waitc(2);
		chk("irq", 1'b0, irq);
		send(8'h00, 8'h00);
		wr(ADDR_EMODE, 32'h0000_0000);
		$display("test strategy done");
		wr(8'h40, 32'h0000_0003);
		wr(8'h60, 32'h0000_0003);
		rdchk(8'h40, 32'h0000_0003, "on delay");
		rdchk(8'h60, 32'h0000_0003, "off delay");
		send(8'h01, 8'h00);
		waitc(15);
		chk("dout", 8'h00, dout);
		waitc(30);
		chk("dout", 8'h01, dout);
		send(8'h00, 8'h00);
		waitc(15);
		chk("dout", 8'h01, dout);
		waitc(30);
		chk("dout", 8'h00, dout);
		seen = 1'b0;
		send(8'h01, 8'h00);
		mon(8);
		send(8'h00, 8'h00);
		mon(50);
		chk("short pulse", 1'b0, seen);
		wr(8'h40, 32'h0000_0000);
		wr(8'h60, 32'h0000_0000);
		$display("test delay done");
		send(8'h0F, 8'h00);
		waitc(8);
		chk("dout", 8'h0F, dout);
		att(1'b1);
		att(1'b1);
		att(1'b0);
		att(1'b1);
		rdchk(ADDR_STATUS, 32'h0000_000F, "status");
		att(1'b1);
		att(1'b1);
		rdchk(ADDR_STATUS, 32'h0002_000F, "status");
		wr(ADDR_IRQ_EN, 32'h0000_0001);
		waitc(4800);
		chk("dout", 8'h0F, dout);
		waitc(300);
		chk("dout", 8'h00, dout);
		rdchk(ADDR_STATUS, 32'h0001_0000, "status");
		chk("irq", 1'b1, irq);
		att(1'b0);
		waitc(8);
		chk("dout", 8'h0F, dout);
		$display("test watchdog done");
		print_verdict();
	end
endmodule
`default_nettype wire
